// File: pkg/sbh_pkg.sv
package sbh_pkg;

	// ************************************************
	// device register map and fields
	// ************************************************
	localparam logic [11:0] DEV_DATA_BUFFER   = 12'h241;
	localparam logic [11:0] DEV_CONTROL_ONE   = 12'h242;
	localparam logic [11:0] DEV_CONTROL_TWO   = 12'h243;
	localparam logic [11:0] DEV_STATUS        = 12'h243;

	localparam int CR2_MASTER_POS             = 7;
	localparam int CR2_TRANSMIT_POS           = 6;
	localparam int CR2_BUS_BUSY_POS           = 5;
	localparam int CR2_PENDING_POS            = 4;
	localparam int CR2_MODE_POS               = 2;

	localparam int CR1_START_POS              = 7;
	localparam int CR1_INHIBIT_POS            = 6;
	localparam int CR1_XFER_MODE_POS          = 4;
	localparam int CR1_CLK_SEL_POS            = 0;

	localparam int SR_BUS_BUSY_POS            = 5;
	localparam int SR_TRANSFER_ACTIVE_POS     = 3;
	localparam int SR_LAST_BIT_POS            = 0;

	localparam logic [1:0] MODE_PORT          = 2'h0;
	localparam logic [1:0] MODE_SYNC_SERIAL   = 2'h1;
	localparam logic [1:0] MODE_TWO_WIRE      = 2'h2;
	localparam logic [2:0] CLK_SEL_EXTERNAL   = 3'h7;

	// ************************************************
	// own apb registers
	// ************************************************
	localparam logic [11:0] APB_CTRL          = 12'h000;
	localparam logic [11:0] APB_DATA          = 12'h004;
	localparam logic [11:0] APB_STATUS        = 12'h008;

	localparam int CTRL_CMD_POS               = 0;
	localparam int CTRL_MODE_POS              = 4;
	localparam int CTRL_XFER_MODE_POS         = 6;
	localparam int CTRL_CLK_SEL_POS           = 8;
	localparam int CTRL_EXT_CLK_POS           = 12;

	localparam logic [2:0] CMD_STATUS_READ    = 3'h0;
	localparam logic [2:0] CMD_STOP           = 3'h1;
	localparam logic [2:0] CMD_RESTART        = 3'h2;
	localparam logic [2:0] CMD_SET_MODE       = 3'h3;
	localparam logic [2:0] CMD_XFER_START     = 3'h4;
	localparam logic [2:0] CMD_XFER_END       = 3'h5;
	localparam logic [2:0] CMD_DATA_WRITE     = 3'h6;
	localparam logic [2:0] CMD_DATA_READ      = 3'h7;

	// ************************************************
	// timing
	// ************************************************
	localparam int CLK_PERIOD_NS              = 25;
	localparam int RESTART_SETUP_NS           = 4700;
	localparam int RESTART_SETUP_CYC          =
		(RESTART_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXT_CLK_MAX_KHZ            = 1700;
	localparam int EXT_HALF_NS                = 1000000 / EXT_CLK_MAX_KHZ / 2;
	localparam int EXT_HALF_CYC               =
		(EXT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [4:0] {
		ST_IDLE      = 5'h00,
		ST_STOP_CHK  = 5'h01,
		ST_STOP_WR   = 5'h02,
		ST_STOP_WAIT = 5'h03,
		ST_RS_WR     = 5'h04,
		ST_RS_BB     = 5'h05,
		ST_RS_LRB    = 5'h06,
		ST_RS_DLY    = 5'h07,
		ST_MD_INH    = 5'h08,
		ST_MD_MODE   = 5'h09,
		ST_MD_CLK    = 5'h0a,
		ST_TX_GO     = 5'h0b,
		ST_END_WR    = 5'h0c,
		ST_END_POLL  = 5'h0d,
		ST_DW        = 5'h0e,
		ST_DR        = 5'h0f,
		ST_SR        = 5'h10
	} sbh_state_type;

endpackage : sbh_pkg

// File: design/sbh_sync.sv
`timescale 1ns/10ps
`default_nettype none

module sbh_sync #(
	parameter int WIDTH = 2
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r   <= '1;
			sync_out <= '1;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : sbh_sync

`default_nettype wire

// File: design/sbh_host.sv
// Contract
// RULE_01 - stop: master,transmit,pending 1, busy 0
// RULE_02 - hold control bits until stop appears
// RULE_03 - device delays stop while clock held
// RULE_04 - device drops busy when clock rises
// RULE_05 - bus free means both pins high
// RULE_06 - restart: clear master,transmit,busy; set pending
// RULE_07 - restart polls busy 0, then last bit 1
// RULE_08 - wait 4.7 us before new start
// RULE_09 - mode change only while stopped and inhibited
// RULE_10 - data buffer accessed, never read-modify-write
// RULE_11 - mode field: port, serial, two-wire, reserved
// RULE_12 - bit count 000 before serial mode
// RULE_13 - control two low bits written 00
// RULE_14 - device offers seven internal clock rates
// RULE_15 - device waits for buffer access
// RULE_16 - select 111 uses external clock pin
// RULE_17 - external clock at most 1.7 MHz
// RULE_18 - data out leading, sampled trailing edge
// RULE_19 - leading edge is falling clock edge
// RULE_20 - trailing edge is rising clock edge
// RULE_21 - serial data least significant bit first
// RULE_22 - transfer flag clears when transfer done
// RULE_23 - shift flag reports shifting, zero after reset
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module sbh_host #(
	parameter int RESTART_CYC  = sbh_pkg::RESTART_SETUP_CYC,
	parameter int EXT_HALF     = sbh_pkg::EXT_HALF_CYC
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// device register port
	output var  logic        dev_req,
	output var  logic        dev_we,
	output var  logic [11:0] dev_addr,
	output var  logic [7:0]  dev_wdata,
	input  wire logic [7:0]  dev_rdata,
	input  wire logic        dev_ack,
	// bus pins sensed as port inputs
	input  wire logic        scl_pin,
	input  wire logic        sda_pin,
	// serial clock pin, driven in external clock mode
	output var  logic        sck_out,
	output var  logic        sck_oe_n
);

	// ************************************************
	// pin synchronisers
	// ************************************************
	logic [1:0] pins_s;

	sbh_sync #(.WIDTH(2)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({scl_pin, sda_pin}),
		.sync_out (pins_s)
	);

	logic bus_free;
	assign bus_free = pins_s[1] & pins_s[0]; // RULE_05

	// ************************************************
	// apb registers
	// ************************************************
	logic        pready_r, pready_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pslverr_r, pslverr_nxt;
	logic [1:0]  mode_r, mode_nxt;
	logic [1:0]  xmode_r, xmode_nxt;
	logic [2:0]  csel_r, csel_nxt;
	logic        ext_r, ext_nxt;
	logic [7:0]  wdata_r, wdata_nxt;
	logic        err_r, err_nxt;
	logic        cmd_go;
	logic [2:0]  cmd;
	logic        busy;
	logic [7:0]  dstat_r, dstat_nxt;
	logic [7:0]  rx_r, rx_nxt;
	sbh_pkg::sbh_state_type state_r, state_nxt;

	assign busy = (state_r != sbh_pkg::ST_IDLE);

	always_comb begin
		logic acc;
		logic mapped;
		acc         = psel & penable & pready_r;
		mapped      = (paddr == sbh_pkg::APB_CTRL) || (paddr == sbh_pkg::APB_DATA)
			|| (paddr == sbh_pkg::APB_STATUS);
		pready_nxt  = psel & penable & ~pready_r;
		prdata_nxt  = prdata_r;
		pslverr_nxt = 1'b0;
		mode_nxt    = mode_r;
		xmode_nxt   = xmode_r;
		csel_nxt    = csel_r;
		ext_nxt     = ext_r;
		wdata_nxt   = wdata_r;
		err_nxt     = err_r;
		cmd_go      = 1'b0;
		cmd         = pwdata[sbh_pkg::CTRL_CMD_POS +: 3];
		if (psel & penable & ~pready_r) begin
			pslverr_nxt = ~mapped;
			unique case (paddr)
				sbh_pkg::APB_CTRL: prdata_nxt = {19'h0, ext_r, 1'b0, csel_r,
					xmode_r, mode_r, 4'h0};
				sbh_pkg::APB_DATA: prdata_nxt = {24'h0, wdata_r};
				sbh_pkg::APB_STATUS: prdata_nxt = {8'h0, rx_r, dstat_r, 4'h0,
					pins_s[0], pins_s[1], bus_free, busy} | {29'h0, err_r, 2'h0};
				default: prdata_nxt = 32'h0;
			endcase
		end
		if (acc && pwrite && paddr == sbh_pkg::APB_CTRL) begin
			if (busy) begin
				err_nxt = 1'b1;
			end else begin
				cmd_go    = 1'b1;
				err_nxt   = 1'b0;
				mode_nxt  = pwdata[sbh_pkg::CTRL_MODE_POS +: 2]; // RULE_11
				xmode_nxt = pwdata[sbh_pkg::CTRL_XFER_MODE_POS +: 2];
				csel_nxt  = pwdata[sbh_pkg::CTRL_CLK_SEL_POS +: 3];
				ext_nxt   = pwdata[sbh_pkg::CTRL_EXT_CLK_POS];
			end
		end
		if (acc && pwrite && paddr == sbh_pkg::APB_DATA && !busy) begin
			wdata_nxt = pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0;
			pslverr_r <= 1'b0;
			mode_r    <= 2'h0;
			xmode_r   <= 2'h0;
			csel_r    <= 3'h0;
			ext_r     <= 1'b0;
			wdata_r   <= 8'h0;
			err_r     <= 1'b0;
		end else begin
			pready_r  <= pready_nxt;
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
			mode_r    <= mode_nxt;
			xmode_r   <= xmode_nxt;
			csel_r    <= csel_nxt;
			ext_r     <= ext_nxt;
			wdata_r   <= wdata_nxt;
			err_r     <= err_nxt;
		end
	end

	assign pready  = pready_r;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;

	// ************************************************
	// command sequencer
	// ************************************************
	logic        req_r, req_nxt;
	logic        we_r, we_nxt;
	logic [11:0] addr_r, addr_nxt;
	logic [7:0]  wd_r, wd_nxt;
	logic [15:0] dly_r, dly_nxt;

	function automatic logic [7:0] cr1_val(input logic start, input logic inh,
		input logic [1:0] xm, input logic [2:0] cs);
		cr1_val = 8'h0;
		cr1_val[sbh_pkg::CR1_START_POS]           = start;
		cr1_val[sbh_pkg::CR1_INHIBIT_POS]         = inh;
		cr1_val[sbh_pkg::CR1_XFER_MODE_POS +: 2]  = xm;
		cr1_val[sbh_pkg::CR1_CLK_SEL_POS +: 3]    = cs;
	endfunction : cr1_val

	function automatic logic [7:0] cr2_val(input logic master_select_bit, input logic pend,
		input logic [1:0] md);
		cr2_val = 8'h0; // RULE_13
		cr2_val[sbh_pkg::CR2_MASTER_POS]   = master_select_bit;
		cr2_val[sbh_pkg::CR2_TRANSMIT_POS] = master_select_bit;
		cr2_val[sbh_pkg::CR2_PENDING_POS]  = pend;
		cr2_val[sbh_pkg::CR2_MODE_POS +: 2] = md;
	endfunction : cr2_val

	always_comb begin
		logic       acc;
		logic       a_we;
		logic [11:0] a_addr;
		logic [7:0] a_data;
		acc       = 1'b1;
		a_we      = 1'b0;
		a_addr    = sbh_pkg::DEV_STATUS;
		a_data    = 8'h0;
		state_nxt = state_r;
		req_nxt   = req_r;
		we_nxt    = we_r;
		addr_nxt  = addr_r;
		wd_nxt    = wd_r;
		dly_nxt   = dly_r;
		dstat_nxt = dstat_r;
		rx_nxt    = rx_r;
		unique case (state_r)
			sbh_pkg::ST_IDLE: begin
				acc = 1'b0;
				if (cmd_go) begin
					unique case (cmd)
						sbh_pkg::CMD_STATUS_READ: state_nxt = sbh_pkg::ST_SR;
						sbh_pkg::CMD_STOP:        state_nxt = sbh_pkg::ST_STOP_CHK;
						sbh_pkg::CMD_RESTART:     state_nxt = sbh_pkg::ST_RS_WR;
						sbh_pkg::CMD_SET_MODE:    state_nxt = sbh_pkg::ST_MD_INH;
						sbh_pkg::CMD_XFER_START:  state_nxt = sbh_pkg::ST_TX_GO;
						sbh_pkg::CMD_XFER_END:    state_nxt = sbh_pkg::ST_END_WR;
						sbh_pkg::CMD_DATA_WRITE:  state_nxt = sbh_pkg::ST_DW;
						sbh_pkg::CMD_DATA_READ:   state_nxt = sbh_pkg::ST_DR;
					endcase
				end
			end
			sbh_pkg::ST_STOP_WR: begin
				a_we   = 1'b1;
				a_addr = sbh_pkg::DEV_CONTROL_TWO;
				a_data = cr2_val(1'b1, 1'b1, mode_r); // RULE_01
			end
			sbh_pkg::ST_STOP_WAIT: begin
				acc = 1'b0;
				if (bus_free) begin // RULE_02
					state_nxt = sbh_pkg::ST_IDLE;
				end
			end
			sbh_pkg::ST_RS_WR: begin
				a_we   = 1'b1;
				a_addr = sbh_pkg::DEV_CONTROL_TWO;
				a_data = cr2_val(1'b0, 1'b1, mode_r); // RULE_06
			end
			sbh_pkg::ST_RS_DLY: begin
				acc     = 1'b0;
				dly_nxt = dly_r - 16'h1;
				if (dly_r == 16'h0) begin // RULE_08
					state_nxt = sbh_pkg::ST_IDLE;
				end
			end
			sbh_pkg::ST_MD_INH: begin
				a_we   = 1'b1;
				a_addr = sbh_pkg::DEV_CONTROL_ONE;
				a_data = cr1_val(1'b0, 1'b1, 2'h0, 3'h0); // RULE_09 RULE_12
			end
			sbh_pkg::ST_MD_MODE: begin
				a_we   = 1'b1;
				a_addr = sbh_pkg::DEV_CONTROL_TWO;
				a_data = cr2_val(1'b0, 1'b0, mode_r); // RULE_11
			end
			sbh_pkg::ST_MD_CLK: begin
				a_we   = 1'b1;
				a_addr = sbh_pkg::DEV_CONTROL_ONE;
				a_data = cr1_val(1'b0, 1'b1, xmode_r, csel_r); // RULE_09
			end
			sbh_pkg::ST_TX_GO: begin
				a_we   = 1'b1;
				a_addr = sbh_pkg::DEV_CONTROL_ONE;
				a_data = cr1_val(1'b1, 1'b0, xmode_r, csel_r);
			end
			sbh_pkg::ST_END_WR: begin
				a_we   = 1'b1;
				a_addr = sbh_pkg::DEV_CONTROL_ONE;
				a_data = cr1_val(1'b0, 1'b0, xmode_r, csel_r);
			end
			sbh_pkg::ST_DW: begin
				a_we   = 1'b1;
				a_addr = sbh_pkg::DEV_DATA_BUFFER; // RULE_10
				a_data = wdata_r;
			end
			sbh_pkg::ST_DR: begin
				a_addr = sbh_pkg::DEV_DATA_BUFFER; // RULE_10
			end
			default: begin
				a_addr = sbh_pkg::DEV_STATUS;
			end
		endcase
		if (acc) begin
			if (!req_r) begin
				req_nxt  = 1'b1;
				we_nxt   = a_we;
				addr_nxt = a_addr;
				wd_nxt   = a_data;
			end else if (dev_ack) begin
				req_nxt = 1'b0;
				if (!we_r && state_r == sbh_pkg::ST_DR) begin
					rx_nxt = dev_rdata;
				end else if (!we_r) begin
					dstat_nxt = dev_rdata;
				end
				unique case (state_r)
					sbh_pkg::ST_STOP_CHK: state_nxt = dev_rdata[sbh_pkg::SR_BUS_BUSY_POS]
						? sbh_pkg::ST_STOP_WR : sbh_pkg::ST_IDLE; // RULE_01
					sbh_pkg::ST_STOP_WR:  state_nxt = sbh_pkg::ST_STOP_WAIT;
					sbh_pkg::ST_RS_WR:    state_nxt = sbh_pkg::ST_RS_BB;
					sbh_pkg::ST_RS_BB:    state_nxt = dev_rdata[sbh_pkg::SR_BUS_BUSY_POS]
						? sbh_pkg::ST_RS_BB : sbh_pkg::ST_RS_LRB; // RULE_07
					sbh_pkg::ST_RS_LRB: begin
						dly_nxt   = 16'(RESTART_CYC - 1);
						state_nxt = dev_rdata[sbh_pkg::SR_LAST_BIT_POS]
							? sbh_pkg::ST_RS_DLY : sbh_pkg::ST_RS_LRB; // RULE_07
					end
					sbh_pkg::ST_MD_INH:   state_nxt = sbh_pkg::ST_MD_MODE;
					sbh_pkg::ST_MD_MODE:  state_nxt = sbh_pkg::ST_MD_CLK;
					sbh_pkg::ST_END_WR:   state_nxt = sbh_pkg::ST_END_POLL;
					sbh_pkg::ST_END_POLL: state_nxt = dev_rdata[sbh_pkg::SR_TRANSFER_ACTIVE_POS]
						? sbh_pkg::ST_END_POLL : sbh_pkg::ST_IDLE; // RULE_22
					default:              state_nxt = sbh_pkg::ST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= sbh_pkg::ST_IDLE;
			req_r   <= 1'b0;
			we_r    <= 1'b0;
			addr_r  <= 12'h0;
			wd_r    <= 8'h0;
			dly_r   <= 16'h0;
			dstat_r <= 8'h0;
			rx_r    <= 8'h0;
		end else begin
			state_r <= state_nxt;
			req_r   <= req_nxt;
			we_r    <= we_nxt;
			addr_r  <= addr_nxt;
			wd_r    <= wd_nxt;
			dly_r   <= dly_nxt;
			dstat_r <= dstat_nxt;
			rx_r    <= rx_nxt;
		end
	end

	assign dev_req   = req_r;
	assign dev_we    = we_r;
	assign dev_addr  = addr_r;
	assign dev_wdata = wd_r;

	// ************************************************
	// external serial clock source
	// ************************************************
	logic        sck_r, sck_nxt;
	logic        oe_n_r, oe_n_nxt;
	logic [7:0]  div_r, div_nxt;

	always_comb begin
		logic run;
		run      = ext_r && csel_r == sbh_pkg::CLK_SEL_EXTERNAL; // RULE_16
		oe_n_nxt = ~run;
		sck_nxt  = sck_r;
		div_nxt  = div_r;
		if (!run) begin
			sck_nxt = 1'b1;
			div_nxt = 8'h0;
		end else if (div_r == 8'(EXT_HALF - 1)) begin // RULE_17
			div_nxt = 8'h0;
			sck_nxt = ~sck_r; // RULE_19 RULE_20
		end else begin
			div_nxt = div_r + 8'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_r  <= 1'b1;
			oe_n_r <= 1'b1;
			div_r  <= 8'h0;
		end else begin
			sck_r  <= sck_nxt;
			oe_n_r <= oe_n_nxt;
			div_r  <= div_nxt;
		end
	end

	assign sck_out  = sck_r;
	assign sck_oe_n = oe_n_r;

endmodule : sbh_host

`default_nettype wire

// File: tb/sbh_host_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sbh_host_asserts (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	// device port
	input wire logic        dev_req,
	input wire logic        dev_we,
	input wire logic [11:0] dev_addr,
	input wire logic [7:0]  dev_wdata,
	input wire logic        dev_ack,
	// serial clock
	input wire logic        sck_out,
	input wire logic        sck_oe_n
);
	logic       wr_done;
	logic       cr2_wr;
	logic [7:0] cr1_r;
	logic [7:0] cr1_nxt;
	assign wr_done = dev_req && dev_ack && dev_we;
	assign cr2_wr  = dev_req && dev_we && dev_addr == 12'h243;
	// ************************************************
	// last control one value written
	// ************************************************
	always_comb begin
		cr1_nxt = (wr_done && dev_addr == 12'h242) ? dev_wdata : cr1_r;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cr1_r <= 8'h00;
		else cr1_r <= cr1_nxt;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_one_wait;
		!pready ##1 pready;
	endsequence
	sequence s_held;
		dev_req && $stable(dev_addr) && $stable(dev_we) && $stable(dev_wdata);
	endsequence
	a_ready_wait: assert property ($rose(penable) && psel |-> s_one_wait)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_err_unmapped: assert property (pready |->
		pslverr == !(paddr inside {12'h000, 12'h004, 12'h008})) else $error("bad pslverr");
	a_req_hold: assert property (dev_req && !dev_ack |=> s_held)
		else $error("device request changed before ack");
	a_ack_release: assert property (dev_req && dev_ack |=> !dev_req) else $error("req kept");
	a_cr2_low: assert property (cr2_wr |-> dev_wdata[1:0] == 2'b00)
		else $error("control two low bits not zero");
	a_stop_value: assert property (cr2_wr && dev_wdata[7] |-> dev_wdata[7:4] == 4'hd)
		else $error("bad stop write");
	a_restart_value: assert property (cr2_wr && dev_wdata[4] && !dev_wdata[7] |->
		dev_wdata[6:5] == 2'b00) else $error("bad restart write");
	a_count_zero: assert property (wr_done && dev_addr == 12'h243 &&
		dev_wdata[7:4] == 4'h0 |-> cr1_r == 8'h40) else $error("mode set without inhibit");
	a_sck_idle: assert property (sck_oe_n |-> sck_out) else $error("serial clock idle low");
endmodule : sbh_host_asserts
bind sbh_host sbh_host_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.dev_req(dev_req), .dev_we(dev_we), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
	.dev_ack(dev_ack), .sck_out(sck_out), .sck_oe_n(sck_oe_n));
`default_nettype wire

// File: tb/sbh_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module sbh_dev_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// register port
	input  wire logic        dev_req,
	input  wire logic        dev_we,
	input  wire logic [11:0] dev_addr,
	input  wire logic [7:0]  dev_wdata,
	input  wire logic [1:0]  lag,
	output var  logic        dev_ack,
	output var  logic [7:0]  dev_rdata,
	// bus pins
	output var  logic        scl_pin,
	output var  logic        sda_pin
);
	logic [7:0]  dbuf, cr1, cr2;
	logic        busy, lrb, act;
	logic [1:0]  cnt;
	logic [19:0] wq[$];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_ack <= 1'b0;
			dev_rdata <= 8'h00;
			{cr1, cr2, busy, lrb, act, cnt} <= '0;
			scl_pin <= 1'b1;
			sda_pin <= 1'b1;
		end else begin
			dev_ack <= 1'b0;
			dev_rdata <= ~dev_rdata;
			scl_pin <= !busy;
			sda_pin <= scl_pin;
			if (dev_req && !dev_ack) begin
				if (cnt != lag) cnt <= cnt + 2'd1;
				else begin
					cnt <= 2'd0;
					dev_ack <= 1'b1;
					if (dev_we) begin
						wq.push_back({dev_addr, dev_wdata});
						if (dev_addr == 12'h241) dbuf <= dev_wdata;
						if (dev_addr == 12'h242) cr1 <= dev_wdata;
						if (dev_addr == 12'h242) act <= act | dev_wdata[7];
						if (dev_addr == 12'h243) cr2 <= dev_wdata;
						if (dev_addr == 12'h243 && dev_wdata[7:4] == 4'hd) busy <= 1'b0;
						if (dev_addr == 12'h243 && dev_wdata[7:4] == 4'h1) begin
							busy <= 1'b0;
							lrb <= 1'b0;
						end
						if (dev_addr == 12'h243 && dev_wdata[7:4] == 4'h0)
							busy <= dev_wdata[3:2] == 2'b10;
					end else if (dev_addr == 12'h241) dev_rdata <= dbuf;
					else begin
						dev_rdata <= {2'b00, busy, 1'b0, act, act, 1'b0, lrb};
						if (!cr1[7]) act <= 1'b0;
						lrb <= !busy;
					end
				end
			end
		end
	end
endmodule : sbh_dev_model
`default_nettype wire

// File: tb/tb_sbh_host.sv
`timescale 1ns/10ps
`default_nettype none
module tb_sbh_host;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr, dev_addr;
	logic [31:0] pwdata, prdata, rd;
	logic        dev_req, dev_we, dev_ack, scl_pin, sda_pin, sck_out, sck_oe_n;
	logic [7:0]  dev_wdata, dev_rdata, byte_v;
	logic [1:0]  lag, xm;
	logic [2:0]  cs;
	logic [19:0] eq[$];
	int          n_fail, num_checks, seed;
	int          cyc = 0;
	int          ack_cyc = 0;
	int          sck_len = 0;
	logic        sck_q = 1'b1;
	logic        sck_seen = 1'b0;
	sbh_host u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_req(dev_req),
		.dev_we(dev_we), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_rdata(dev_rdata),
		.dev_ack(dev_ack), .scl_pin(scl_pin), .sda_pin(sda_pin), .sck_out(sck_out),
		.sck_oe_n(sck_oe_n));
	sbh_dev_model u_dev (.pclk(pclk), .presetn(presetn), .dev_req(dev_req), .dev_we(dev_we),
		.dev_addr(dev_addr), .dev_wdata(dev_wdata), .lag(lag), .dev_ack(dev_ack),
		.dev_rdata(dev_rdata), .scl_pin(scl_pin), .sda_pin(sda_pin));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			test_done;
		end
	end
	// ************************************************
	// last device answer and serial clock half periods
	// ************************************************
	always @(posedge pclk) begin
		if (dev_req && dev_ack) ack_cyc <= cyc;
		sck_q   <= sck_out;
		sck_len <= (sck_out !== sck_q) ? 1 : sck_len + 1;
		if (sck_oe_n) sck_seen <= 1'b0;
		else if (sck_out !== sck_q) begin
			sck_seen <= 1'b1;
			if (sck_seen) check(32'(sck_len), 32'(sbh_pkg::EXT_HALF_CYC));
			else check({31'h0, sck_out}, 32'h0);
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask : check
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task exp(input logic [11:0] a, input logic [7:0] d);
		eq.push_back({a, d});
	endtask : exp
	// ************************************************
	// issue a command, wait idle, compare device writes
	// ************************************************
	task cmd(input logic [2:0] c, input logic [1:0] m);
		lag <= 2'($random(seed));
		apb(1'b1, 12'h000, {19'h0, cs == 3'h7, 1'b0, cs, xm, m, 1'b0, c});
		repeat (200) begin
			apb(1'b0, 12'h008, 32'h0);
			if (rd[0] === 1'b0) break;
		end
		check(32'(rd[0]), 32'h0);
		check(32'(u_dev.wq.size()), 32'(eq.size()));
		while (eq.size() > 0 && u_dev.wq.size() > 0)
			check(32'(u_dev.wq.pop_front()), 32'(eq.pop_front()));
		eq.delete();
		u_dev.wq.delete();
	endtask : cmd
	task setmode(input logic [1:0] m);
		exp(12'h242, 8'h40);
		exp(12'h243, {4'h0, m, 2'b00});
		exp(12'h242, {2'b01, xm, 1'b0, cs});
		cmd(3'h3, m);
	endtask : setmode
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	initial begin
		seed = 76;
		{n_fail, num_checks} = '0;
		{presetn, psel, penable, pwrite, paddr, pwdata, lag} = '0;
		xm = 2'($random(seed));
		cs = 3'($random(seed));
		if (cs == 3'h7) cs = 3'h6;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h008, 32'h0);
		check(32'(rd[1:0]), 32'h2);
		check({31'h0, sck_oe_n}, 32'h1);
		apb(1'b0, 12'h00c, 32'h0);
		check({rd[30:0], err}, 32'h1);
		for (int m = 0; m < 3; m++) setmode(2'(m));
		exp(12'h243, 8'h18);
		cmd(3'h2, 2'h2);
		check(32'(rd[15:8]), 32'h01);
		check(32'(cyc - ack_cyc > sbh_pkg::RESTART_SETUP_CYC), 32'h1);
		setmode(2'h2);
		exp(12'h243, 8'hd8);
		cmd(3'h1, 2'h2);
		check(32'(rd[1:0]), 32'h2);
		cmd(3'h1, 2'h2);
		cs = 3'h7;
		setmode(2'h1);
		repeat (4) @(posedge pclk);
		check({31'h0, sck_oe_n}, 32'h0);
		exp(12'h242, {2'b10, xm, 1'b0, cs});
		cmd(3'h4, 2'h1);
		byte_v = 8'($random(seed));
		apb(1'b1, 12'h004, {24'h0, byte_v});
		exp(12'h241, byte_v);
		cmd(3'h6, 2'h1);
		cmd(3'h7, 2'h1);
		check(32'(rd[23:16]), {24'h0, byte_v});
		exp(12'h242, {2'b00, xm, 1'b0, cs});
		cmd(3'h5, 2'h1);
		check(32'(rd[11:10]), 32'h0);
		cmd(3'h0, 2'h1);
		check(32'(rd[15:8]), 32'h01);
		test_done;
	end
endmodule : tb_sbh_host
`default_nettype wire
